// [include/custom_logic_consts.vh]
// constants shared by the custom logic block files
`ifndef CUSTOM_LOGIC_CONSTS_VH
`define CUSTOM_LOGIC_CONSTS_VH

// ----------------------------------------------------------------
// input source select codes
// ----------------------------------------------------------------
`define INSEL_OFF       4'h0
`define INSEL_FEEDBACK  4'h1
`define INSEL_LINK      4'h2
`define INSEL_EVENT_A   4'h3
`define INSEL_EVENT_B   4'h4
`define INSEL_PIN       4'h5
`define INSEL_COMP      4'h6
`define INSEL_ZCROSS    4'h7
`define INSEL_USART     4'h8
`define INSEL_SPI       4'h9
`define INSEL_TIMER_A   4'hA
`define INSEL_TIMER_B   4'hB
`define INSEL_TIMER_D   4'hC

// ----------------------------------------------------------------
// output filter select codes
// ----------------------------------------------------------------
`define FILT_OFF        2'h0
`define FILT_SYNC       2'h1
`define FILT_FILTER     2'h2

// ----------------------------------------------------------------
// unit clock source codes
// ----------------------------------------------------------------
`define UNIT_CLOCK_SOURCE_PERIPH   1'h0
`define UNIT_CLOCK_SOURCE_PIN2     1'h1

// ----------------------------------------------------------------
// sequencer function select codes
// ----------------------------------------------------------------
`define SEQ_OFF         4'h0
`define SEQ_DFF         4'h1
`define SEQ_JK          4'h2
`define SEQ_DLATCH      4'h3
`define SEQ_RS          4'h4

// ----------------------------------------------------------------
// output change event modes
// ----------------------------------------------------------------
`define INT_NONE        2'h0
`define INT_RISE        2'h1
`define INT_FALL        2'h2
`define INT_BOTH        2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RESET_TRUTH     8'h00
`define RESET_INSEL     4'h0

`endif

// [logic/unit_output_stage.v]
// synchronizer, glitch filter and rising-edge detector of one unit
`timescale 1ns/1ps
`default_nettype none
`include "custom_logic_consts.vh"

module unit_output_stage (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // control
  input  wire       tick,
  input  wire       unitOn,
  input  wire [1:0] filterMode,
  input  wire       edgeOn,
  // data
  input  wire       lutIn,
  output wire       stageOut
);

  reg  [2:0] shift_q;
  reg        held_q;
  reg        prevOut_q;
  wire       filtered;

  // ----------------------------------------------------------------
  // filter shift chain
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_q   <= 3'h0;
      held_q    <= 1'b0;
      prevOut_q <= 1'b0;
    end else if (!unitOn) begin
      shift_q   <= 3'h0;
      held_q    <= 1'b0;
      prevOut_q <= 1'b0;
    end else if (tick) begin
      shift_q <= {shift_q[1:0], lutIn};
      if (shift_q[0] == shift_q[1] && shift_q[1] == shift_q[2]) begin
        held_q <= shift_q[2];
      end
      prevOut_q <= filtered;
    end
  end

  // off is combinational, sync is two edges
  assign filtered = (filterMode == `FILT_SYNC)   ? shift_q[1] :
                    (filterMode == `FILT_FILTER) ? held_q :
                    lutIn;

  assign stageOut = edgeOn ? (filtered & ~prevOut_q) : filtered;

endmodule
`default_nettype wire

// [logic/pair_sequencer.v]
// sequencer fed by the even and odd unit of one pair
`timescale 1ns/1ps
`default_nettype none
`include "custom_logic_consts.vh"

module pair_sequencer (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // control
  input  wire       tick,
  input  wire       clear,
  input  wire [3:0] funcSel,
  // data
  input  wire       evenIn,
  input  wire       oddIn,
  output wire       seqOut
);

  reg state_q;
  reg state_d;

  always @* begin
    state_d = state_q;
    case (funcSel)
      `SEQ_DFF: begin
        if (oddIn) state_d = evenIn;
      end
      `SEQ_JK: begin
        case ({evenIn, oddIn})
          2'b01:   state_d = 1'b0;
          2'b10:   state_d = 1'b1;
          2'b11:   state_d = ~state_q;
          default: state_d = state_q;
        endcase
      end
      default: state_d = state_q;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= 1'b0;
    end else if (clear) begin
      state_q <= 1'b0;
    end else if (funcSel == `SEQ_DLATCH) begin
      // latches follow on every cycle, not only on unit ticks
      if (oddIn) state_q <= evenIn;
    end else if (funcSel == `SEQ_RS) begin
      if (evenIn && !oddIn) state_q <= 1'b1;
      else if (oddIn && !evenIn) state_q <= 1'b0;
    end else if (tick) begin
      state_q <= state_d;
    end
  end

  assign seqOut = state_q;

endmodule
`default_nettype wire

// [logic/custom_logic_block.v]
// four-unit programmable lookup logic with pair sequencers
`timescale 1ns/1ps
`default_nettype none
`include "custom_logic_consts.vh"

module custom_logic_block (
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // main control
  input  wire        mainWrite,
  input  wire        mainEnable,
  // unit control write, selected by unitSel
  input  wire        ctrlWrite,
  input  wire [1:0]  unitSel,
  input  wire        unitEnable,
  input  wire [1:0]  outputFilterSelect,
  input  wire        edgeDetectEnable,
  input  wire        unitClockSource,
  input  wire [1:0]  interruptMode,
  input  wire [3:0]  input0SourceSelect,
  input  wire [3:0]  input1SourceSelect,
  input  wire [3:0]  input2SourceSelect,
  // truth table write, selected by unitSel
  input  wire        truthWrite,
  input  wire [7:0]  truthTableBits,
  // sequencer control write
  input  wire        seqWrite,
  input  wire        sequencer_function_select,
  input  wire [3:0]  sequencerFunctionSelect,
  // unit pins, events and peripheral outputs
  input  wire [11:0] unitInputPins,
  input  wire [3:0]  eventInputA,
  input  wire [3:0]  eventInputB,
  input  wire        analogComparatorOut,
  input  wire        zeroCrossDetectorOut,
  input  wire        usart0Tx,
  input  wire        usart1Tx,
  input  wire        spiMosi,
  input  wire        spiSck,
  input  wire [2:0]  timerA0Wave,
  input  wire [2:0]  timerBWave,
  input  wire [2:0]  timerD0Wave,
  // outputs
  output wire [3:0]  unitOutputPin,
  output wire [1:0]  sequencerOut,
  output reg  [3:0]  unitChangeEvent,
  output wire        interruptRequest,
  // status
  output wire        globalEnabled,
  output wire [3:0]  unitEnabled
);

  // ----------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------
  reg        globalEn_q;
  reg [3:0]  enable_q;
  reg [7:0]  filter_q;
  reg [3:0]  edge_q;
  reg [3:0]  unit_clock_source_q;
  reg [7:0]  intMode_q;
  reg [15:0] input0_source_select_q;
  reg [15:0] input1_source_select_q;
  reg [15:0] input2_source_select_q;
  reg [31:0] truth_q;
  reg [7:0]  seqFunc_q;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function evenOff;
    input [1:0] unit;
    input [3:0] en;
    begin
      evenOff = ~en[{unit[1], 1'b0}];
    end
  endfunction

  function pickSource;
    input [3:0]  code;
    input [12:0] src;
    begin
      if (code > `INSEL_TIMER_D) pickSource = 1'b0;
      else pickSource = src[code];
    end
  endfunction

  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      globalEn_q <= 1'b0;
      enable_q   <= 4'h0;
      filter_q   <= 8'h00;
      edge_q     <= 4'h0;
      unit_clock_source_q   <= 4'h0;
      intMode_q  <= 8'h00;
      input0_source_select_q   <= 16'h0000;
      input1_source_select_q   <= 16'h0000;
      input2_source_select_q   <= 16'h0000;
      truth_q    <= 32'h00000000;
      seqFunc_q  <= 8'h00;
    end else begin
      if (mainWrite) globalEn_q <= mainEnable;
      if (ctrlWrite) begin
        enable_q[unitSel] <= unitEnable;
        intMode_q[2*unitSel +: 2] <= interruptMode;
        if (evenOff(unitSel, enable_q)) begin
          filter_q[2*unitSel +: 2] <= outputFilterSelect;
          edge_q[unitSel]          <= edgeDetectEnable;
          unit_clock_source_q[unitSel]        <= unitClockSource;
          input0_source_select_q[4*unitSel +: 4] <= input0SourceSelect;
          input1_source_select_q[4*unitSel +: 4] <= input1SourceSelect;
          input2_source_select_q[4*unitSel +: 4] <= input2SourceSelect;
        end
      end
      if (truthWrite && evenOff(unitSel, enable_q)) begin
        truth_q[8*unitSel +: 8] <= truthTableBits;
      end
      if (seqWrite && !enable_q[{sequencer_function_select, 1'b0}]) begin
        seqFunc_q[4*sequencer_function_select +: 4] <= sequencerFunctionSelect;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin synchronizers
  // ----------------------------------------------------------------
  reg [11:0] pinMeta_q;
  reg [11:0] pinSync_q;
  reg [3:0]  pin2Prev_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_q  <= 12'h000;
      pinSync_q  <= 12'h000;
      pin2Prev_q <= 4'h0;
    end else begin
      pinMeta_q  <= unitInputPins;
      pinSync_q  <= pinMeta_q;
      pin2Prev_q <= {pinSync_q[11], pinSync_q[8], pinSync_q[5], pinSync_q[2]};
    end
  end

  // ----------------------------------------------------------------
  // per-unit datapath
  // ----------------------------------------------------------------
  wire [3:0] unitOn;
  wire [3:0] unitTick;
  wire [3:0] stageOut;
  wire [3:0] unitOut;
  wire [1:0] seqQ;
  reg  [3:0] linkOut_q;

  genvar n;
  generate
    for (n = 0; n < 4; n = n + 1) begin : unitGen
      wire [12:0] src0;
      wire [12:0] src1;
      wire [12:0] src2;
      wire [2:0]  truthIndex;
      wire        pin2;
      wire        fb;
      wire        link;
      wire        lutVal;

      assign fb   = seqQ[n / 2];
      // next unit link, registered to keep the ring free of loops
      assign link = linkOut_q[(n + 1) % 4];
      assign pin2 = pinSync_q[3*n + 2];

      // source vectors indexed by select code
      assign src0 = {timerD0Wave[0], timerBWave[0], timerA0Wave[0], spiMosi, usart0Tx,
                     1'b0, analogComparatorOut, pinSync_q[3*n],
                     eventInputB[n], eventInputA[n], link, fb, 1'b0};
      assign src1 = {timerD0Wave[1], timerBWave[1], timerA0Wave[1], spiMosi, usart1Tx,
                     zeroCrossDetectorOut, analogComparatorOut, pinSync_q[3*n + 1],
                     eventInputB[n], eventInputA[n], link, fb, 1'b0};
      assign src2 = {timerD0Wave[2], timerBWave[2], timerA0Wave[2], spiSck, usart1Tx,
                     1'b0, analogComparatorOut, pin2,
                     eventInputB[n], eventInputA[n], link, fb, 1'b0};

      // input 2 reads low when it clocks the unit
      assign truthIndex = {
        (unit_clock_source_q[n] == `UNIT_CLOCK_SOURCE_PIN2) ? 1'b0 : pickSource(input2_source_select_q[4*n +: 4], src2),
        pickSource(input1_source_select_q[4*n +: 4], src1),
        pickSource(input0_source_select_q[4*n +: 4], src0)};

      assign lutVal = truth_q[8*n + truthIndex];

      assign unitOn[n] = globalEn_q & enable_q[n];

      // unit clock from pin 2 rising edge
      assign unitTick[n] = (unit_clock_source_q[n] == `UNIT_CLOCK_SOURCE_PIN2) ? (pin2 & ~pin2Prev_q[n]) : 1'b1;

      unit_output_stage stage (
        .clk        (clk),
        .resetn     (resetn),
        .tick       (unitTick[n]),
        .unitOn     (unitOn[n]),
        .filterMode (filter_q[2*n +: 2]),
        .edgeOn     (edge_q[n]),
        .lutIn      (lutVal),
        .stageOut   (stageOut[n])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // sequencers
  // ----------------------------------------------------------------
  generate
    for (n = 0; n < 2; n = n + 1) begin : seqGen
      // pair sequencer on even unit clock
      pair_sequencer seq (
        .clk     (clk),
        .resetn  (resetn),
        .tick    (unitTick[2*n]),
        .clear   (~unitOn[2*n]),
        .funcSel (seqFunc_q[4*n +: 4]),
        .evenIn  (stageOut[2*n]),
        .oddIn   (stageOut[2*n + 1]),
        .seqOut  (seqQ[n])
      );
    end
  endgenerate

  // gate outputs; an active sequencer takes over its even unit output
  assign unitOut[0] = unitOn[0] & ((seqFunc_q[3:0] != `SEQ_OFF) ? seqQ[0] : stageOut[0]);
  assign unitOut[1] = unitOn[1] & stageOut[1];
  assign unitOut[2] = unitOn[2] & ((seqFunc_q[7:4] != `SEQ_OFF) ? seqQ[1] : stageOut[2]);
  assign unitOut[3] = unitOn[3] & stageOut[3];

  assign unitOutputPin = unitOut;
  assign sequencerOut  = seqQ;

  // ----------------------------------------------------------------
  // output change events
  // ----------------------------------------------------------------
  reg [3:0] change_d;
  integer   k;

  always @* begin
    change_d = 4'h0;
    for (k = 0; k < 4; k = k + 1) begin
      case (intMode_q[2*k +: 2])
        `INT_RISE: change_d[k] = unitOut[k] & ~linkOut_q[k];
        `INT_FALL: change_d[k] = ~unitOut[k] & linkOut_q[k];
        `INT_BOTH: change_d[k] = unitOut[k] ^ linkOut_q[k];
        default:   change_d[k] = 1'b0;
      endcase
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      linkOut_q       <= 4'h0;
      unitChangeEvent <= 4'h0;
    end else begin
      linkOut_q       <= unitOut;
      unitChangeEvent <= change_d;
    end
  end

  assign interruptRequest = |unitChangeEvent;

  assign globalEnabled = globalEn_q;
  assign unitEnabled   = enable_q;

endmodule
`default_nettype wire

// [sim/custom_logic_asserts.sv]
// port-level checks for the custom logic block
`timescale 1ns/1ps
`default_nettype none
module custom_logic_asserts (
  // clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // control writes
  input wire logic       mainWrite,
  input wire logic       mainEnable,
  input wire logic       ctrlWrite,
  input wire logic [1:0] unitSel,
  input wire logic       unitEnable,
  // results
  input wire logic [3:0] unitOutputPin,
  input wire logic [1:0] sequencerOut,
  input wire logic [3:0] unitChangeEvent,
  input wire logic       interruptRequest,
  input wire logic       globalEnabled,
  input wire logic [3:0] unitEnabled
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ----
  // sequences
  // ----
  sequence s_main_write;
    mainWrite ##1 1'b1;
  endsequence
  sequence s_pair0_off;
    (!(globalEnabled && unitEnabled[0])) [*2];
  endsequence
  chk_main_enable: assert property (s_main_write |-> globalEnabled == $past(mainEnable))
    else $error("global enable does not follow its write");
  chk_main_hold: assert property (!mainWrite |=> $stable(globalEnabled))
    else $error("global enable moved without a write");
  chk_unit_enable: assert property (ctrlWrite |=>
    unitEnabled[$past(unitSel)] == $past(unitEnable))
    else $error("unit enable does not follow its write");
  chk_unit_hold: assert property (!ctrlWrite |=> $stable(unitEnabled))
    else $error("unit enable moved without a write");
  chk_out_off: assert property ((unitOutputPin & ~(unitEnabled & {4{globalEnabled}})) == 4'h0)
    else $error("disabled unit drives its output");
  chk_irq_or: assert property (interruptRequest == (|unitChangeEvent))
    else $error("interrupt request differs from the unit events");
  chk_seq_clear: assert property (s_pair0_off |-> sequencerOut[0] == 1'b0)
    else $error("sequencer not cleared with pair disabled");
  chk_event_cause: assert property (
    (unitChangeEvent & ~($past(unitOutputPin) ^ $past(unitOutputPin, 2))) == 4'h0)
    else $error("unit event without an output change");
endmodule
`default_nettype wire

// [sim/periph_model.sv]
// far side: unit pins, event lines and peripheral levels
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  // pins and events
  output var logic [11:0] unitInputPins,
  output var logic [3:0]  eventInputA,
  output var logic [3:0]  eventInputB,
  // comparator, zero-cross, serial and timer levels
  output var logic [14:0] periphLevels
);
  initial begin
    unitInputPins = 12'h000;
    eventInputA = 4'h0;
    eventInputB = 4'h0;
    // serial ports run as hosts, transmit idles high
    periphLevels = 15'h000C;
  end
endmodule
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the custom logic block
`timescale 1ns/1ps
`default_nettype none
`include "custom_logic_consts.vh"
module tb;
  logic        clk, resetn, mainWrite, mainEnable, ctrlWrite, unitEnable;
  logic        edgeDetectEnable, unitClockSource, truthWrite, seqWrite, sequencer_function_select;
  logic [1:0]  unitSel, outputFilterSelect, interruptMode;
  logic [3:0]  input0SourceSelect, input1SourceSelect, input2SourceSelect;
  logic [3:0]  sequencerFunctionSelect;
  logic [7:0]  truthTableBits, hits;
  wire  [11:0] unitInputPins;
  wire  [14:0] pv;
  wire  [3:0]  eventInputA, eventInputB, unitOutputPin, unitChangeEvent, unitEnabled;
  wire  [1:0]  sequencerOut;
  wire         interruptRequest, globalEnabled;
  int          err_count, checks_done, n;
  logic [3:0]  codes [6] = '{`INSEL_COMP, `INSEL_USART, `INSEL_SPI, `INSEL_TIMER_A,
                             `INSEL_TIMER_B, `INSEL_TIMER_D};
  int          pos [6] = '{0, 2, 4, 6, 9, 12};
  custom_logic_block u_custom_logic_block (
    .clk, .resetn, .mainWrite, .mainEnable, .ctrlWrite, .unitSel, .unitEnable,
    .outputFilterSelect, .edgeDetectEnable, .unitClockSource, .interruptMode,
    .input0SourceSelect, .input1SourceSelect, .input2SourceSelect, .truthWrite,
    .truthTableBits, .seqWrite, .sequencer_function_select, .sequencerFunctionSelect, .unitInputPins,
    .eventInputA, .eventInputB, .analogComparatorOut(pv[0]), .zeroCrossDetectorOut(pv[1]),
    .usart0Tx(pv[2]), .usart1Tx(pv[3]), .spiMosi(pv[4]), .spiSck(pv[5]),
    .timerA0Wave(pv[8:6]), .timerBWave(pv[11:9]), .timerD0Wave(pv[14:12]),
    .unitOutputPin, .sequencerOut, .unitChangeEvent, .interruptRequest,
    .globalEnabled, .unitEnabled);
  periph_model u_periph_model (
    .unitInputPins, .eventInputA, .eventInputB, .periphLevels(pv));
  // ----
  // tasks
  // ----
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr_main(input logic e);
    mainEnable = e;
    mainWrite = 1'b1;
    tick(1);
    mainWrite = 1'b0;
    tick(1);
  endtask
  task automatic wr_truth(input logic [1:0] u, input logic [7:0] t);
    unitSel = u;
    truthTableBits = t;
    truthWrite = 1'b1;
    tick(1);
    truthWrite = 1'b0;
    tick(1);
  endtask
  task automatic wr_seq(input logic [3:0] f);
    sequencerFunctionSelect = f;
    seqWrite = 1'b1;
    tick(1);
    seqWrite = 1'b0;
    tick(1);
  endtask
  task automatic wr_ctrl(input logic [1:0] u, input logic en, input logic [1:0] f,
                         input logic ed, input logic [1:0] im, input logic [3:0] s0);
    unitSel = u;
    unitEnable = en;
    outputFilterSelect = f;
    edgeDetectEnable = ed;
    interruptMode = im;
    input0SourceSelect = s0;
    ctrlWrite = 1'b1;
    tick(1);
    ctrlWrite = 1'b0;
    tick(1);
  endtask
  // counts high cycles of one unit output, or of the request when b is 4
  task automatic count(input int b);
    hits = 8'h00;
    repeat (8) begin
      tick(1);
      hits = hits + ((b == 4) ? interruptRequest : unitOutputPin[b]);
    end
  endtask
  // ----
  // clock, watchdog, tests
  // ----
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    err_count++;
    close_out;
  end
  initial begin
    {mainWrite, mainEnable, ctrlWrite, unitEnable, edgeDetectEnable, unitClockSource} = '0;
    {truthWrite, seqWrite, sequencer_function_select, unitSel, outputFilterSelect, interruptMode} = '0;
    {input0SourceSelect, input1SourceSelect, input2SourceSelect} = '0;
    {sequencerFunctionSelect, truthTableBits} = '0;
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    wr_main(1'b1);
    chk("global", globalEnabled, 8'h01);
    input1SourceSelect = `INSEL_EVENT_B;
    input2SourceSelect = `INSEL_COMP;
    wr_truth(2'h0, 8'h42);
    wr_ctrl(2'h0, 1'b1, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    for (n = 0; n < 8; n++) begin
      u_periph_model.eventInputA[0] = n[0];
      u_periph_model.eventInputB[0] = n[1];
      u_periph_model.periphLevels[0] = n[2];
      #1;
      chk("index", unitOutputPin[0], (8'h42 >> n) & 8'h01);
    end
    wr_ctrl(2'h0, 1'b0, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_OFF);
    input1SourceSelect = `INSEL_OFF;
    input2SourceSelect = `INSEL_OFF;
    wr_truth(2'h0, 8'h01);
    wr_ctrl(2'h0, 1'b1, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_OFF);
    chk("off", unitOutputPin[0], 8'h01);
    wr_truth(2'h0, 8'h00);
    chk("locked", unitOutputPin[0], 8'h01);
    wr_main(1'b0);
    chk("gl_off", unitOutputPin[0], 8'h00);
    wr_main(1'b1);
    wr_ctrl(2'h0, 1'b0, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_OFF);
    chk("u_off", unitOutputPin[0], 8'h00);
    wr_truth(2'h0, 8'hAA);
    for (n = 0; n < 6; n++) begin
      wr_ctrl(2'h0, 1'b0, `FILT_OFF, 1'b0, `INT_NONE, codes[n]);
      wr_ctrl(2'h0, 1'b1, `FILT_OFF, 1'b0, `INT_NONE, codes[n]);
      u_periph_model.periphLevels = 15'h0001 << pos[n];
      #1;
      chk("per_hi", unitOutputPin[0], 8'h01);
      u_periph_model.periphLevels = ~(15'h0001 << pos[n]);
      #1;
      chk("per_lo", unitOutputPin[0], 8'h00);
    end
    wr_ctrl(2'h0, 1'b0, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    wr_truth(2'h1, 8'hAA);
    wr_ctrl(2'h1, 1'b1, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_PIN);
    u_periph_model.unitInputPins[3] = 1'b1;
    tick(3);
    chk("pin", unitOutputPin[1], 8'h01);
    u_periph_model.unitInputPins[3] = 1'b0;
    wr_ctrl(2'h0, 1'b1, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    wr_truth(2'h3, 8'hAA);
    wr_ctrl(2'h3, 1'b1, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_LINK);
    u_periph_model.eventInputA[0] = 1'b1;
    tick(2);
    chk("link", unitOutputPin[3], 8'h01);
    u_periph_model.eventInputA[0] = 1'b0;
    wr_ctrl(2'h1, 1'b1, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_OFF);
    u_periph_model.unitInputPins[3] = 1'b1;
    tick(3);
    chk("odd_lock", unitOutputPin[1], 8'h01);
    wr_ctrl(2'h0, 1'b0, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    wr_ctrl(2'h1, 1'b1, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    for (n = 1; n < 5; n++) begin
      wr_ctrl(2'h0, 1'b0, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_EVENT_A);
      u_periph_model.eventInputA[1:0] = 2'b00;
      wr_seq(n[3:0]);
      wr_ctrl(2'h0, 1'b1, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_EVENT_A);
      u_periph_model.eventInputA[1:0] = 2'b01;
      tick(4);
      chk("seq_a", sequencerOut, {7'h00, n == 2 || n == 4});
      u_periph_model.eventInputA[1:0] = {1'b1, n[0]};
      tick(4);
      chk("seq_b", sequencerOut, {7'h00, n[0]});
    end
    wr_ctrl(2'h0, 1'b0, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    wr_seq(`SEQ_OFF);
    wr_truth(2'h2, 8'hAA);
    wr_ctrl(2'h2, 1'b1, `FILT_SYNC, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    u_periph_model.eventInputA[2] = 1'b1;
    tick(1);
    chk("sync1", unitOutputPin[2], 8'h00);
    tick(1);
    chk("sync2", unitOutputPin[2], 8'h01);
    wr_ctrl(2'h2, 1'b0, `FILT_SYNC, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    u_periph_model.eventInputA[2] = 1'b0;
    wr_ctrl(2'h2, 1'b1, `FILT_FILTER, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    tick(4);
    u_periph_model.eventInputA[2] = 1'b1;
    tick(2);
    u_periph_model.eventInputA[2] = 1'b0;
    count(2);
    chk("spike", hits, 8'h00);
    u_periph_model.eventInputA[2] = 1'b1;
    tick(3);
    chk("filt3", unitOutputPin[2], 8'h00);
    tick(1);
    chk("filt4", unitOutputPin[2], 8'h01);
    wr_ctrl(2'h2, 1'b0, `FILT_FILTER, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    u_periph_model.eventInputA[2] = 1'b0;
    wr_ctrl(2'h2, 1'b1, `FILT_SYNC, 1'b1, `INT_NONE, `INSEL_EVENT_A);
    chk("cleared", unitOutputPin[2], 8'h00);
    tick(3);
    u_periph_model.eventInputA[2] = 1'b1;
    count(2);
    chk("edge", hits, 8'h01);
    wr_ctrl(2'h2, 1'b0, `FILT_SYNC, 1'b1, `INT_NONE, `INSEL_EVENT_A);
    wr_ctrl(2'h2, 1'b1, `FILT_SYNC, 1'b1, `INT_NONE, `INSEL_EVENT_A);
    count(2);
    chk("edge_clr", hits, 8'h01);
    wr_ctrl(2'h0, 1'b1, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    for (n = 1; n < 4; n++) begin
      wr_ctrl(2'h3, 1'b1, `FILT_OFF, 1'b0, n[1:0], `INSEL_LINK);
      u_periph_model.eventInputA[0] = 1'b1;
      count(4);
      chk("irq_rise", hits, {7'h00, n[0]});
      u_periph_model.eventInputA[0] = 1'b0;
      count(4);
      chk("irq_fall", hits, {7'h00, n[1]});
    end
    // sequencer one feeds unit 3 back, zero-cross masks it on input 1
    wr_ctrl(2'h2, 1'b0, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    sequencer_function_select = 1'b1;
    wr_seq(`SEQ_RS);
    wr_truth(2'h3, 8'h02);
    input1SourceSelect = `INSEL_ZCROSS;
    wr_ctrl(2'h3, 1'b1, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_FEEDBACK);
    input1SourceSelect = `INSEL_OFF;
    wr_ctrl(2'h2, 1'b1, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    tick(2);
    chk("zc_mask", unitOutputPin[3], 8'h00);
    chk("seq_one", sequencerOut, 8'h02);
    u_periph_model.periphLevels[1] = 1'b0;
    #1;
    chk("fb_set", unitOutputPin[3], 8'h01);
    // unit 1 clocked by its input 2 pin, which reads low in the index
    wr_ctrl(2'h0, 1'b0, `FILT_OFF, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    {unitClockSource, input2SourceSelect} = {`UNIT_CLOCK_SOURCE_PIN2, `INSEL_PIN};
    wr_truth(2'h1, 8'h02);
    wr_ctrl(2'h1, 1'b0, `FILT_SYNC, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    wr_ctrl(2'h1, 1'b1, `FILT_SYNC, 1'b0, `INT_NONE, `INSEL_EVENT_A);
    {unitClockSource, input2SourceSelect} = {`UNIT_CLOCK_SOURCE_PERIPH, `INSEL_OFF};
    tick(6);
    chk("pclk_idle", unitOutputPin[1], 8'h00);
    for (n = 0; n < 2; n++) begin
      u_periph_model.unitInputPins[5] = 1'b1;
      tick(4);
      chk("pclk", unitOutputPin[1], {7'h00, n[0]});
      u_periph_model.unitInputPins[5] = 1'b0;
      tick(4);
    end
    close_out;
  end
endmodule
bind custom_logic_block custom_logic_asserts u_chk (
  .clk(clk), .resetn(resetn), .mainWrite(mainWrite), .mainEnable(mainEnable),
  .ctrlWrite(ctrlWrite), .unitSel(unitSel), .unitEnable(unitEnable),
  .unitOutputPin(unitOutputPin), .sequencerOut(sequencerOut),
  .unitChangeEvent(unitChangeEvent), .interruptRequest(interruptRequest),
  .globalEnabled(globalEnabled), .unitEnabled(unitEnabled));
`default_nettype wire
